// ==== include/led_seq_pkg.sv ====
// Overview of operation
// - Management booting: its lamp blinks 0.5 s on/off, chassis lamp dark.
// - Management ready in standby: chassis lamp repeats 0.1 s on, 2.9 s off.
// - Power-on request: chassis lamp blinks 0.5 s on/off, mgmt lamp steady.
// - Host booted: chassis lamp steady; both steady means main power mode.
// - Each locate button press toggles the locate fast blink.
// - Summary fault lamp on while any replaceable component lamp is lit.
// - Chassis lamp off without AC power or before management firmware boots.
// - Chassis lamp 1000 ms slow blink during self-test and during shutdown.
// - Chassis lamp steady once host powered and self-test complete.
// - Management lamp off when stopped, slow blink booting, steady when up.
// - Fan fault lamp steady while any fan module reports failure.
// - Supply fault lamp steady while any power supply reports failure.
// - Overtemperature lamp steady while the warning condition is signalled.
// - Service-hold lamp lit only on host application request.
package led_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int SLOW_HALF_MS = 500;
  localparam int SLOW_PERIOD_MS = 1000;
  localparam int STBY_ON_MS = 100;
  localparam int STBY_OFF_MS = 2900;
  localparam int STBY_PERIOD_MS = STBY_ON_MS + STBY_OFF_MS;
  localparam int FAST_PERIOD_MS = 250;
  localparam int FAST_HALF_MS = FAST_PERIOD_MS / 2;
  // the common frame must be a multiple of every pattern period
  localparam int FRAME_MS = STBY_PERIOD_MS;
  localparam int MS_W = 12;
  localparam int TICK_W = 15;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  localparam int CTRL_LOCATE_BIT = 0;
  localparam logic CTRL_LOCATE_RST = 1'b0;

  localparam int ST_MGMT_BIT = 0;
  localparam int ST_CHASSIS_BIT = 1;
  localparam int ST_LOCATE_BIT = 2;
  localparam int ST_FAULT_BIT = 3;
  localparam int ST_FAN_BIT = 4;
  localparam int ST_SUPPLY_BIT = 5;
  localparam int ST_TEMP_BIT = 6;
  localparam int ST_HOLD_BIT = 7;
  localparam int ST_STATE_LSB = 8;

  localparam int EV_FAN = 0;
  localparam int EV_SUPPLY = 1;
  localparam int EV_TEMP = 2;
  localparam int EV_BUTTON = 3;
  localparam int EV_CHASSIS = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] IRQ_STAT_RST = 5'h00;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;

  typedef enum logic [2:0] {
    CH_OFF,
    CH_STANDBY,
    CH_POWERING,
    CH_MAIN,
    CH_SHUTDOWN
  } chassis_e;

endpackage : led_seq_pkg

// ==== design/pin_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,                // system clock
  input wire logic rst,                // synchronous reset
  input wire logic [WIDTH-1:0] d,      // asynchronous pins
  output logic [WIDTH-1:0] q           // synchronised copy
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ==== design/led_sequencer.sv ====
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module led_sequencer #(
  parameter int NUM_FANS = 4,
  parameter int NUM_PSU = 2,
  parameter int NUM_COMP = 8,
  parameter int CYC_PER_MS = led_seq_pkg::CYC_PER_MS
) (
  input wire logic SYS_CLK,                    // 20 MHz system clock
  input wire logic RST,                        // synchronous reset
  input wire logic AC_PRESENT,                 // AC input present
  input wire logic MGMT_RUNNING,               // mgmt_processor running
  input wire logic MGMT_READY,                 // mgmt_processor fully up
  input wire logic HOST_PWR_ON,                // power-on requested
  input wire logic HOST_POWERED,               // host rails up
  input wire logic POST_DONE,                  // self-test checkpoints done
  input wire logic LOCATE_BTN,                 // locate button, high pressed
  input wire logic [NUM_COMP-1:0] COMP_FAULT,  // component fault lamps
  input wire logic [NUM_FANS-1:0] FAN_FAIL,    // fan module failed
  input wire logic [NUM_PSU-1:0] PSU_FAIL,     // power supply failed
  input wire logic OVERTEMP,                   // overtemperature warning
  input wire logic HOST_HOLD_REQ,              // host asks service hold
  input wire logic [7:0] ADDR,                 // register byte address
  input wire logic [31:0] WDATA,               // write data
  input wire logic WR,                         // write strobe
  input wire logic RD,                         // read strobe
  output logic [31:0] RDATA,                   // read data, next cycle
  output logic IRQ,                            // level interrupt
  output logic MGMT_HEALTH_LAMP,               // mgmt_health_lamp
  output logic CHASSIS_HEALTH_LAMP,            // chassis health lamp
  output logic LOCATE_LAMP,                    // white locate lamp
  output logic FAULT_LAMP,                     // amber summary fault
  output logic FAN_FAULT_LAMP,                 // amber fan fault
  output logic SUPPLY_FAULT_LAMP,              // supply_fault_lamp
  output logic OVERTEMP_LAMP,                  // amber overtemp warning
  output logic SERVICE_HOLD_LAMP               // white service hold
);

  localparam int PIN_W = 9 + NUM_COMP + NUM_FANS + NUM_PSU;
  localparam int MS_W = led_seq_pkg::MS_W;
  localparam int TICK_W = led_seq_pkg::TICK_W;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_s;
  logic ac_s, run_s, ready_s, pwr_on_s, powered_s, post_s;
  logic btn_s, temp_s, hold_s;
  logic [NUM_COMP-1:0] comp_s;
  logic [NUM_FANS-1:0] fan_s;
  logic [NUM_PSU-1:0] psu_s;

  pin_sync #(.WIDTH(PIN_W)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({AC_PRESENT, MGMT_RUNNING, MGMT_READY, HOST_PWR_ON, HOST_POWERED,
        POST_DONE, LOCATE_BTN, OVERTEMP, HOST_HOLD_REQ, COMP_FAULT,
        FAN_FAIL, PSU_FAIL}),
    .q(pins_s)
  );

  assign {ac_s, run_s, ready_s, pwr_on_s, powered_s, post_s, btn_s, temp_s,
          hold_s, comp_s, fan_s, psu_s} = pins_s;

  // ----------------------------------------------------------------
  // pattern timebase
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tick_r;
  logic [MS_W-1:0] ms_r;
  logic ms_tick;
  logic slow_on, stby_on, fast_on;

  assign ms_tick = (tick_r == TICK_W'(CYC_PER_MS - 1));

  // one shared frame keeps lamps with equal patterns in phase
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      tick_r <= '0;
    end else if (ms_tick) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ms_r <= '0;
    end else if (ms_tick) begin
      if (ms_r == MS_W'(led_seq_pkg::FRAME_MS - 1)) begin
        ms_r <= '0;
      end else begin
        ms_r <= ms_r + 1'b1;
      end
    end
  end

  assign slow_on = (ms_r % MS_W'(led_seq_pkg::SLOW_PERIOD_MS))
                   < MS_W'(led_seq_pkg::SLOW_HALF_MS);
  assign stby_on = ms_r < MS_W'(led_seq_pkg::STBY_ON_MS);
  assign fast_on = (ms_r % MS_W'(led_seq_pkg::FAST_PERIOD_MS))
                   < MS_W'(led_seq_pkg::FAST_HALF_MS);

  // ----------------------------------------------------------------
  // chassis power sequence
  // ----------------------------------------------------------------
  led_seq_pkg::chassis_e state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      led_seq_pkg::CH_OFF: begin
        state_nxt = led_seq_pkg::CH_STANDBY;
      end
      led_seq_pkg::CH_STANDBY: begin
        if (pwr_on_s) begin
          state_nxt = led_seq_pkg::CH_POWERING;
        end
      end
      led_seq_pkg::CH_POWERING: begin
        if (!pwr_on_s) begin
          state_nxt = led_seq_pkg::CH_SHUTDOWN;
        end else if (post_s) begin
          state_nxt = led_seq_pkg::CH_MAIN;
        end
      end
      led_seq_pkg::CH_MAIN: begin
        if (!pwr_on_s) begin
          state_nxt = led_seq_pkg::CH_SHUTDOWN;
        end
      end
      led_seq_pkg::CH_SHUTDOWN: begin
        if (!powered_s) begin
          state_nxt = led_seq_pkg::CH_STANDBY;
        end
      end
      default: begin
        state_nxt = led_seq_pkg::CH_OFF;
      end
    endcase
    // no AC or firmware not booted forces the sequence back
    if (!ac_s || !ready_s) begin
      state_nxt = led_seq_pkg::CH_OFF;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_r <= led_seq_pkg::CH_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register slave and locate state
  // ----------------------------------------------------------------
  logic wr_ctrl, wr_mask, rd_stat;
  logic btn_d_r, press;
  logic locate_r;
  logic [led_seq_pkg::EV_W-1:0] irq_stat_r, irq_mask_r, events;
  logic [NUM_FANS-1:0] fan_d_r;
  logic [NUM_PSU-1:0] psu_d_r;
  logic temp_d_r;
  logic [31:0] status_w, rdata_nxt;

  assign wr_ctrl = WR && (ADDR == led_seq_pkg::ADDR_CTRL);
  assign wr_mask = WR && (ADDR == led_seq_pkg::ADDR_IRQ_MASK);
  assign rd_stat = RD && (ADDR == led_seq_pkg::ADDR_IRQ_STAT);
  assign press = btn_s && !btn_d_r;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      btn_d_r <= 1'b0;
      fan_d_r <= '0;
      psu_d_r <= '0;
      temp_d_r <= 1'b0;
    end else begin
      btn_d_r <= btn_s;
      fan_d_r <= fan_s;
      psu_d_r <= psu_s;
      temp_d_r <= temp_s;
    end
  end

  // a press in the cycle of a software write still toggles the new value
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      locate_r <= led_seq_pkg::CTRL_LOCATE_RST;
    end else begin
      locate_r <= (wr_ctrl ? WDATA[led_seq_pkg::CTRL_LOCATE_BIT] : locate_r)
                  ^ press;
    end
  end

  assign events[led_seq_pkg::EV_FAN] = |(fan_s & ~fan_d_r);
  assign events[led_seq_pkg::EV_SUPPLY] = |(psu_s & ~psu_d_r);
  assign events[led_seq_pkg::EV_TEMP] = temp_s && !temp_d_r;
  assign events[led_seq_pkg::EV_BUTTON] = press;
  assign events[led_seq_pkg::EV_CHASSIS] = state_nxt != state_r;

  // read clears, but an event in the same cycle survives
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_stat_r <= led_seq_pkg::IRQ_STAT_RST;
    end else begin
      irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | events;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_mask_r <= led_seq_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_r <= WDATA[led_seq_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  always_comb begin
    status_w = '0;
    status_w[led_seq_pkg::ST_MGMT_BIT] = MGMT_HEALTH_LAMP;
    status_w[led_seq_pkg::ST_CHASSIS_BIT] = CHASSIS_HEALTH_LAMP;
    status_w[led_seq_pkg::ST_LOCATE_BIT] = locate_r;
    status_w[led_seq_pkg::ST_FAULT_BIT] = FAULT_LAMP;
    status_w[led_seq_pkg::ST_FAN_BIT] = FAN_FAULT_LAMP;
    status_w[led_seq_pkg::ST_SUPPLY_BIT] = SUPPLY_FAULT_LAMP;
    status_w[led_seq_pkg::ST_TEMP_BIT] = OVERTEMP_LAMP;
    status_w[led_seq_pkg::ST_HOLD_BIT] = SERVICE_HOLD_LAMP;
    status_w[led_seq_pkg::ST_STATE_LSB +: 3] = state_r;
  end

  // unmapped addresses read as zero
  always_comb begin
    rdata_nxt = '0;
    if (RD) begin
      unique case (ADDR)
        led_seq_pkg::ADDR_CTRL: begin
          rdata_nxt[led_seq_pkg::CTRL_LOCATE_BIT] = locate_r;
        end
        led_seq_pkg::ADDR_STATUS: begin
          rdata_nxt = status_w;
        end
        led_seq_pkg::ADDR_IRQ_STAT: begin
          rdata_nxt[led_seq_pkg::EV_W-1:0] = irq_stat_r;
        end
        led_seq_pkg::ADDR_IRQ_MASK: begin
          rdata_nxt[led_seq_pkg::EV_W-1:0] = irq_mask_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= '0;
    end else begin
      RDATA <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // lamp drivers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MGMT_HEALTH_LAMP <= 1'b0;
    end else if (!ac_s || !run_s) begin
      MGMT_HEALTH_LAMP <= 1'b0;
    end else begin
      MGMT_HEALTH_LAMP <= ready_s || slow_on;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      CHASSIS_HEALTH_LAMP <= 1'b0;
    end else begin
      unique case (state_r)
        led_seq_pkg::CH_STANDBY: CHASSIS_HEALTH_LAMP <= stby_on;
        led_seq_pkg::CH_POWERING: CHASSIS_HEALTH_LAMP <= slow_on;
        led_seq_pkg::CH_SHUTDOWN: CHASSIS_HEALTH_LAMP <= slow_on;
        led_seq_pkg::CH_MAIN: CHASSIS_HEALTH_LAMP <= 1'b1;
        default: CHASSIS_HEALTH_LAMP <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      LOCATE_LAMP <= 1'b0;
      FAULT_LAMP <= 1'b0;
      FAN_FAULT_LAMP <= 1'b0;
      SUPPLY_FAULT_LAMP <= 1'b0;
      OVERTEMP_LAMP <= 1'b0;
      SERVICE_HOLD_LAMP <= 1'b0;
    end else begin
      LOCATE_LAMP <= locate_r && fast_on;
      // fan and supply faults light their own component lamps too
      FAULT_LAMP <= |comp_s || |fan_s || |psu_s;
      FAN_FAULT_LAMP <= |fan_s;
      SUPPLY_FAULT_LAMP <= |psu_s;
      OVERTEMP_LAMP <= temp_s;
      SERVICE_HOLD_LAMP <= hold_s;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_mgmt_blink: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ac_s && run_s && !ready_s) |=> (MGMT_HEALTH_LAMP == $past(slow_on)))
    else $error("mgmt lamp not slow blinking while booting");

  a_standby_blink: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_r == led_seq_pkg::CH_STANDBY) |=>
      (CHASSIS_HEALTH_LAMP == ($past(ms_r) < 12'h064)))
    else $error("standby pattern wrong");

  a_powering_blink: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_r == led_seq_pkg::CH_POWERING && ready_s && run_s && ac_s) |=>
      (CHASSIS_HEALTH_LAMP == $past(slow_on)) && MGMT_HEALTH_LAMP)
    else $error("powering lamps wrong");

  a_main_steady: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_r == led_seq_pkg::CH_MAIN) |=> CHASSIS_HEALTH_LAMP)
    else $error("chassis lamp not steady in main mode");

  a_locate_fast: assert property (@(posedge SYS_CLK) disable iff (RST)
    locate_r |=> (LOCATE_LAMP == ($past(ms_r) % 12'h0fa < 12'h07d)))
    else $error("locate fast blink wrong");

  a_button_toggle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (press && !wr_ctrl) |=> (locate_r != $past(locate_r)))
    else $error("button press did not toggle locate");

  a_fault_summary: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (FAULT_LAMP == $past(|comp_s || |fan_s || |psu_s)))
    else $error("summary fault lamp wrong");

  a_chassis_dark: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!ac_s || !ready_s) |=> ##1 !CHASSIS_HEALTH_LAMP)
    else $error("chassis lamp lit without AC or firmware");

  a_shutdown_blink: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_r == led_seq_pkg::CH_SHUTDOWN) |=>
      (CHASSIS_HEALTH_LAMP == ($past(ms_r) % 12'h3e8 < 12'h1f4)))
    else $error("shutdown blink wrong");

  a_post_to_main: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state_r == led_seq_pkg::CH_POWERING && pwr_on_s && post_s && ac_s
     && ready_s) |=> ##1 CHASSIS_HEALTH_LAMP)
    else $error("chassis lamp not steady after self-test");

  a_mgmt_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!run_s || !ac_s) |=> !MGMT_HEALTH_LAMP)
    else $error("mgmt lamp lit while not running");

  a_fan_lamp: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (FAN_FAULT_LAMP == $past(|fan_s)))
    else $error("fan lamp wrong");

  a_supply_lamp: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 (SUPPLY_FAULT_LAMP == $past(|psu_s)))
    else $error("supply lamp wrong");

  a_temp_lamp: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(temp_s) |=> OVERTEMP_LAMP)
    else $error("overtemp lamp late");

  a_hold_lamp: assert property (@(posedge SYS_CLK) disable iff (RST)
    !hold_s |=> !SERVICE_HOLD_LAMP)
    else $error("service hold lamp lit without request");

  a_reset_dark: assert property (@(posedge SYS_CLK)
    RST |=> !(MGMT_HEALTH_LAMP || CHASSIS_HEALTH_LAMP || LOCATE_LAMP
              || FAULT_LAMP || FAN_FAULT_LAMP || SUPPLY_FAULT_LAMP
              || OVERTEMP_LAMP || SERVICE_HOLD_LAMP))
    else $error("lamp lit after reset");

  a_frame_wrap: assert property (@(posedge SYS_CLK) disable iff (RST)
    (ms_tick && ms_r == 12'hbb7) |=> (ms_r == 12'h000))
    else $error("frame counter did not wrap");

endmodule : led_sequencer
`default_nettype wire

// ==== bench/host_side_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// service processor, host and sensors seen from the lamp logic
// ----------------------------------------------------------------
// phase: 0 no AC, 1 mgmt booting, 2 standby, 3 powering, 4 main,
// 5 shutdown with rails still up, 6 standby after shutdown
module host_side_model (
  input wire logic clk,          // system clock
  input wire logic rst,          // synchronous reset
  input wire logic [2:0] phase,  // power sequence step
  input wire logic hold_want,    // host application wants hold
  output logic ac_present,       // AC present
  output logic mgmt_running,     // mgmt_processor running
  output logic mgmt_ready,       // mgmt_processor fully up
  output logic host_pwr_on,      // power-on request
  output logic host_powered,     // host rails up
  output logic post_done,        // self-test finished
  output logic hold_req          // service hold request
);
  always_ff @(posedge clk) begin
    if (rst) begin
      ac_present <= 1'b0;
      mgmt_running <= 1'b0;
      mgmt_ready <= 1'b0;
      host_pwr_on <= 1'b0;
      host_powered <= 1'b0;
      post_done <= 1'b0;
      hold_req <= 1'b0;
    end else begin
      ac_present <= phase != 3'h0;
      mgmt_running <= phase != 3'h0;
      mgmt_ready <= phase >= 3'h2;
      host_pwr_on <= phase == 3'h3 || phase == 3'h4;
      host_powered <= phase >= 3'h3 && phase <= 3'h5;
      post_done <= phase == 3'h4;
      hold_req <= hold_want;
    end
  end
endmodule : host_side_model
`default_nettype wire

// ==== bench/led_sequencer_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module led_sequencer_test;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // short ms tick keeps a 3000 ms frame at 30000 cycles
  localparam int CPM = 10;
  logic sys_clk, rst, ac, run, rdy, pwr_on, powered, post, hold;
  logic btn, temp, wr_s, rd_s, hold_want, irq;
  logic [2:0] phase;
  logic [7:0] comp, addr;
  logic [3:0] fan;
  logic [1:0] psu;
  logic [31:0] wdata, rdata, d;
  logic mgmt_l, ch_l, loc_l, flt_l, fan_l, sup_l, tmp_l, hold_l;
  int n_fail = 0;
  int n_compared = 0;

  led_sequencer #(.CYC_PER_MS(CPM)) i_led_sequencer (
    .SYS_CLK(sys_clk), .RST(rst), .AC_PRESENT(ac), .MGMT_RUNNING(run),
    .MGMT_READY(rdy), .HOST_PWR_ON(pwr_on), .HOST_POWERED(powered),
    .POST_DONE(post), .LOCATE_BTN(btn), .COMP_FAULT(comp),
    .FAN_FAIL(fan), .PSU_FAIL(psu), .OVERTEMP(temp),
    .HOST_HOLD_REQ(hold), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
    .RD(rd_s), .RDATA(rdata), .IRQ(irq), .MGMT_HEALTH_LAMP(mgmt_l),
    .CHASSIS_HEALTH_LAMP(ch_l), .LOCATE_LAMP(loc_l), .FAULT_LAMP(flt_l),
    .FAN_FAULT_LAMP(fan_l), .SUPPLY_FAULT_LAMP(sup_l),
    .OVERTEMP_LAMP(tmp_l), .SERVICE_HOLD_LAMP(hold_l));

  host_side_model i_host_side_model (
    .clk(sys_clk), .rst(rst), .phase(phase), .hold_want(hold_want),
    .ac_present(ac), .mgmt_running(run), .mgmt_ready(rdy),
    .host_pwr_on(pwr_on), .host_powered(powered), .post_done(post),
    .hold_req(hold));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cnt(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(posedge sys_clk);
    v = rdata;
  endtask : rd

  task automatic press;
    @(posedge sys_clk);
    btn <= 1'b1;
    cyc(4);
    btn <= 1'b0;
  endtask : press

  // on-cycles and rising edges of mgmt, chassis, locate over n cycles;
  // a whole period makes both counts independent of phase
  task automatic frame(input int n, input int m_on, m_r, c_on, c_r,
                       l_on, l_r);
    logic [2:0] l;
    logic [2:0] p;
    int on [3];
    int r [3];
    on = '{0, 0, 0};
    r = '{0, 0, 0};
    p = {mgmt_l, ch_l, loc_l};
    repeat (n) begin
      @(posedge sys_clk);
      l = {mgmt_l, ch_l, loc_l};
      for (int i = 0; i < 3; i++) begin
        if (l[i] === 1'b1) on[i]++;
        if (p[i] === 1'b0 && l[i] === 1'b1) r[i]++;
      end
      p = l;
    end
    chk_cnt(on[2], m_on);
    chk_cnt(r[2], m_r);
    chk_cnt(on[1], c_on);
    chk_cnt(r[1], c_r);
    chk_cnt(on[0], l_on);
    chk_cnt(r[0], l_r);
  endtask : frame

  task automatic go(input logic [2:0] ph);
    @(posedge sys_clk);
    phase <= ph;
    cyc(20);
  endtask : go

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    phase = 3'h0;
    hold_want = 1'b0;
    btn = 1'b0;
    comp = 8'h00;
    fan = 4'h0;
    psu = 2'h0;
    temp = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    cyc(6);
    chk({mgmt_l, ch_l, loc_l, flt_l, fan_l, sup_l, tmp_l, hold_l}, 0);
    rst <= 1'b0;
    go(3'h1);
    wr(led_seq_pkg::ADDR_CTRL, 32'h1);
    rd(led_seq_pkg::ADDR_CTRL, d);
    chk(d, 32'h1);
    cyc(10);
    frame(10000, 5000, 1, 0, 0, 5000, 4);
    go(3'h2);
    frame(30000, 30000, 0, 1000, 1, 15000, 12);
    go(3'h3);
    press();
    cyc(10);
    frame(10000, 10000, 0, 5000, 1, 0, 0);
    rd(led_seq_pkg::ADDR_STATUS, d);
    chk(d[10:8], 3'h2);
    go(3'h4);
    press();
    cyc(10);
    frame(10000, 10000, 0, 10000, 0, 5000, 4);
    rd(led_seq_pkg::ADDR_STATUS, d);
    chk(d[10:8], 3'h3);
    go(3'h5);
    frame(10000, 10000, 0, 5000, 1, 5000, 4);
    go(3'h6);
    rd(led_seq_pkg::ADDR_STATUS, d);
    chk(d[10:8], 3'h1);
    // faults and interrupts; presses and state changes left their events
    rd(led_seq_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h18);
    wr(led_seq_pkg::ADDR_IRQ_MASK, 32'h1);
    rd(led_seq_pkg::ADDR_IRQ_MASK, d);
    chk(d, 32'h1);
    fan <= 4'h4;
    cyc(6);
    chk({fan_l, flt_l, irq}, 3'h7);
    rd(led_seq_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h1);
    cyc(3);
    chk(irq, 1'b0);
    fan <= 4'h0;
    psu <= 2'h2;
    cyc(6);
    chk({sup_l, flt_l, irq}, 3'h6);
    rd(led_seq_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h2);
    psu <= 2'h0;
    comp <= 8'h80;
    cyc(6);
    chk({flt_l, fan_l, sup_l}, 3'h4);
    comp <= 8'h00;
    temp <= 1'b1;
    hold_want <= 1'b1;
    cyc(8);
    chk({tmp_l, flt_l, hold_l}, 3'h5);
    rd(led_seq_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h4);
    temp <= 1'b0;
    hold_want <= 1'b0;
    cyc(8);
    chk({flt_l, fan_l, sup_l, tmp_l, hold_l}, 5'h00);
    rd(8'h10, d);
    chk(d, 32'h0);
    go(3'h0);
    chk({mgmt_l, ch_l}, 2'h0);
    rd(led_seq_pkg::ADDR_IRQ_STAT, d);
    chk(d, 32'h10);
    end_sim();
  end

  // hang guard: the sequence needs about 70300 cycles
  initial begin
    cyc(95000);
    n_fail++;
    end_sim();
  end
endmodule : led_sequencer_test
`default_nettype wire
